//--- universal_port.sv
// Eight-pin universal port with change detection, as an APB slave.
// Assumes pin inputs synchronous to ref_clk_i; pad logic combines the enables.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "uport_cfg.svh"
module universal_port #(
   parameter int PIN_W = 8
) (
   input wire logic ref_clk_i, // Device clock, 100 MHz
   input wire logic sys_rst_i, // Synchronous reset, active high
   input wire logic clk_en_i, // Freezes all state while low
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic pwrite_i, // APB direction
   input wire logic [11:0] paddr_i, // APB byte address
   input wire logic [31:0] pwdata_i, // APB write data
   output logic [31:0] prdata_o, // APB read data
   output logic pready_o, // APB ready
   output logic pslverr_o, // APB error, unmapped address
   input wire logic [PIN_W-1:0] port_pin_i, // Pad levels
   output logic [PIN_W-1:0] port_pin_o, // Pad drive levels
   output logic [PIN_W-1:0] port_pin_oe_n_o, // Low while driving
   output logic port_irq_o, // Shared port interrupt request
   output logic irq_o // Block level interrupt, enabled events
);
   initial begin
      if (PIN_W != 8) $error("universal_port supports eight pins only");
   end

   logic [PIN_W-1:0] dir_r, mask_r, out_r, sync1_r, sync2_r, prev_r;
   logic [PIN_W-1:0] flag_r, pend_r;
   logic [7:0] port_cfg_r;
   logic summary_r;
   logic [1:0] ien_r, ist_r;
   logic [1:0] ev_nxt;
   logic edge_ok_r;
   uport_pkg::apb_phase_e phase_r;

   logic [6:0] idx;
   logic addr_ok, word_ok, acc_go, rd_go, wr_go;
   logic stat_rd;
   logic [PIN_W-1:0] chg, new_evt, vis_flag, act_flag;
   logic [31:0] rd_val;

   assign idx = paddr_i[8:2];
   assign word_ok = (paddr_i[1:0] == 2'h0) && (paddr_i[11:9] == 3'h0);
   assign acc_go = clk_en_i && psel_i && penable_i && (phase_r == uport_pkg::APB_ACCESS);
   assign rd_go = acc_go && !pwrite_i;
   // Misaligned or out-of-range writes are refused and must not land
   assign wr_go = acc_go && pwrite_i && word_ok;

   always_comb begin
      addr_ok = 1'b0;
      case (idx)
         `UP_IDX_VALUE_A, `UP_IDX_VALUE_B,
         `UP_IDX_STAT_A, `UP_IDX_STAT_B,
         `UP_IDX_DIR_A, `UP_IDX_DIR_B,
         `UP_IDX_PORT_CFG_A, `UP_IDX_PORT_CFG_B,
         `UP_IDX_IEN, `UP_IDX_IST: addr_ok = word_ok;
         `UP_IDX_SUMMARY_A, `UP_IDX_SUMMARY_B: addr_ok = word_ok && !pwrite_i;
         `UP_IDX_ICLR: addr_ok = word_ok && pwrite_i;
         default: addr_ok = 1'b0;
      endcase
   end

   assign stat_rd = rd_go && word_ok && ((idx == `UP_IDX_STAT_A) || (idx == `UP_IDX_STAT_B));

   assign chg = edge_ok_r ? (sync2_r ^ prev_r) : '0;
   assign new_evt = chg & dir_r;

   // masked hidden unless visible
   // A flag raised before its pin was masked again is hidden as well
   assign vis_flag = port_cfg_r[`UP_VISIBLE_BIT] ? (flag_r | pend_r) : (flag_r & ~mask_r);
   assign act_flag = flag_r & ~mask_r;

   always_comb begin
      rd_val = 32'h0;
      case (idx)
         `UP_IDX_VALUE_A, `UP_IDX_VALUE_B: rd_val[PIN_W-1:0] = sync2_r;
         `UP_IDX_STAT_A, `UP_IDX_STAT_B: rd_val[PIN_W-1:0] = vis_flag;
         `UP_IDX_DIR_A, `UP_IDX_DIR_B: rd_val[PIN_W-1:0] = dir_r;
         `UP_IDX_PORT_CFG_A, `UP_IDX_PORT_CFG_B: rd_val[7:0] = port_cfg_r;
         `UP_IDX_SUMMARY_A, `UP_IDX_SUMMARY_B: rd_val[`UP_SUMMARY_PORT_BIT] = summary_r;
         `UP_IDX_IEN: rd_val[1:0] = ien_r;
         `UP_IDX_IST: rd_val[1:0] = ist_r;
         default: rd_val = 32'h0;
      endcase
   end

   // APB slave: one wait-free access cycle after setup
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         phase_r <= uport_pkg::APB_SETUP;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0;
      end else if (clk_en_i) begin
         if (psel_i && !penable_i) begin
            phase_r <= uport_pkg::APB_ACCESS;
            pready_o <= 1'b1;
            pslverr_o <= !addr_ok;
            prdata_o <= (addr_ok && !pwrite_i) ? rd_val : 32'h0;
         end else begin
            phase_r <= uport_pkg::APB_SETUP;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         // Preload pin levels so that release shows no false edge
         sync1_r <= port_pin_i;
         sync2_r <= port_pin_i;
         prev_r <= port_pin_i;
         edge_ok_r <= 1'b0;
      end else if (clk_en_i) begin
         sync1_r <= port_pin_i;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
         edge_ok_r <= 1'b1;
      end
   end

   // Direction and output drive
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         dir_r <= `UP_DIR_RST;
         out_r <= '0;
      end else if (clk_en_i && wr_go) begin
         if ((idx == `UP_IDX_DIR_A) || (idx == `UP_IDX_DIR_B)) begin
            dir_r <= pwdata_i[PIN_W-1:0];
         end
         if ((idx == `UP_IDX_VALUE_A) || (idx == `UP_IDX_VALUE_B)) begin
            out_r <= (out_r & dir_r) | (pwdata_i[PIN_W-1:0] & ~dir_r);
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         port_pin_o <= '0;
         port_pin_oe_n_o <= '1;
      end else if (clk_en_i) begin
         port_pin_o <= out_r & ~dir_r;
         port_pin_oe_n_o <= dir_r;
      end
   end

   // Mask and interrupt configuration
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         mask_r <= `UP_MASK_RST;
         port_cfg_r <= `UP_PORT_CFG_RST;
         ien_r <= `UP_IEN_RST;
      end else if (clk_en_i && wr_go) begin
         if ((idx == `UP_IDX_STAT_A) || (idx == `UP_IDX_STAT_B)) begin
            mask_r <= pwdata_i[PIN_W-1:0];
         end
         if ((idx == `UP_IDX_PORT_CFG_A) || (idx == `UP_IDX_PORT_CFG_B)) begin
            port_cfg_r <= pwdata_i[7:0];
         end
         if (idx == `UP_IDX_IEN) begin
            ien_r <= pwdata_i[1:0];
         end
      end
   end

   // Per-pin change flag and pending store
   genvar g;
   generate
      for (g = 0; g < PIN_W; g++) begin : g_pin
         always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
               flag_r[g] <= 1'b0;
               pend_r[g] <= 1'b0;
            end else if (clk_en_i) begin
               if (!mask_r[g]) begin
                  flag_r[g] <= new_evt[g] || pend_r[g] || (flag_r[g] && !stat_rd);
                  pend_r[g] <= 1'b0;
               end else begin
                  pend_r[g] <= new_evt[g] ||
                     (pend_r[g] && !(stat_rd && port_cfg_r[`UP_VISIBLE_BIT]));
                  flag_r[g] <= flag_r[g] && !stat_rd;
               end
            end
         end
      end
   endgenerate

   // Summary bit and port interrupt line
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         summary_r <= 1'b0;
         port_irq_o <= 1'b0;
      end else if (clk_en_i) begin
         summary_r <= (|(new_evt & ~mask_r)) || (|(pend_r & ~mask_r)) ||
            ((summary_r || (|act_flag)) && !stat_rd);
         port_irq_o <= |act_flag;
      end
   end

   assign ev_nxt[`UP_EV_CHANGE] = |(new_evt & ~mask_r);
   assign ev_nxt[`UP_EV_PENDING] = |(new_evt & mask_r);

   // Sticky events; set beats a coincident clear
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ist_r <= 2'h0;
         irq_o <= 1'b0;
      end else if (clk_en_i) begin
         if (wr_go && (idx == `UP_IDX_ICLR)) begin
            ist_r <= (ist_r & ~pwdata_i[1:0]) | ev_nxt;
         end else begin
            ist_r <= ist_r | ev_nxt;
         end
         irq_o <= |(ist_r & ien_r);
      end
   end
endmodule : universal_port

//--- uport_cfg.svh
// Register map, field positions and reset values of the universal port.
// Included by the design and the bench; definitions only.
`ifndef UPORT_CFG_SVH
`define UPORT_CFG_SVH
// Printed offsets are indices (not multiples of four); byte address = 4 * index
`define UP_IDX_VALUE_A 7'h3c
`define UP_IDX_VALUE_B 7'h7c
`define UP_IDX_STAT_A 7'h3d
`define UP_IDX_STAT_B 7'h7d
`define UP_IDX_DIR_A 7'h3e
`define UP_IDX_DIR_B 7'h7e
`define UP_IDX_PORT_CFG_A 7'h39
`define UP_IDX_PORT_CFG_B 7'h79
`define UP_IDX_SUMMARY_A 7'h38
`define UP_IDX_SUMMARY_B 7'h78
`define UP_IDX_IEN 7'h10
`define UP_IDX_ICLR 7'h11
`define UP_IDX_IST 7'h12
`define UP_VISIBLE_BIT 7
`define UP_SUMMARY_PORT_BIT 0
`define UP_DIR_RST 8'hff
`define UP_MASK_RST 8'hff
`define UP_PORT_CFG_RST 8'h00
`define UP_IEN_RST 2'h0
`define UP_EV_CHANGE 0
`define UP_EV_PENDING 1
`endif

//--- uport_pkg.sv
// Types shared by the universal port design.
// Constants live in uport_cfg.svh.
package uport_pkg;
   typedef enum logic [1:0] {
      APB_SETUP = 2'b01,
      APB_ACCESS = 2'b10
   } apb_phase_e;
endpackage : uport_pkg

//--- universal_port_properties.sv
// Concurrent checks on the APB face and pins of the universal port.
// Bound into every universal_port; sees only that module's ports.
`timescale 1ns/1ps
module universal_port_checker #(
   parameter int PIN_W = 8
) (
   input wire logic ref_clk_i, sys_rst_i, clk_en_i, psel_i, penable_i, pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i, prdata_o,
   input wire logic pready_o, pslverr_o, port_irq_o, irq_o,
   input wire logic [PIN_W-1:0] port_pin_i, port_pin_o, port_pin_oe_n_o
);
   logic [PIN_W-1:0] pin_d_r;
   logic [3:0] quiet_r;
   logic [3:0] wr_age_r;
   logic acc_w;
   assign acc_w = psel_i && penable_i && pready_o && pwrite_i;
   // Cycles since a pin moved and since a mask write; irq edges must trace to one
   // Ages freeze with the clock enable, as the port itself does
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pin_d_r <= port_pin_i;
         quiet_r <= 4'h0;
         wr_age_r <= 4'hf;
      end else if (clk_en_i) begin
         pin_d_r <= port_pin_i;
         quiet_r <= (port_pin_i != pin_d_r) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
         wr_age_r <= (acc_w && paddr_i[7:2] == 6'h3d) ? 4'h0 :
            wr_age_r + {3'h0, wr_age_r != 4'hf};
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i || !clk_en_i);
   a_ready_pulse: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
      else $error("ready is not a single pulse after setup");
   a_err_unmapped: assert property (psel_i && !penable_i && paddr_i[7:2] == 6'h3f |=> pslverr_o)
      else $error("unmapped access not refused");
   a_upper_zero: assert property (prdata_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_oe_follow: assert property (
      acc_w && paddr_i[7:2] == 6'h3e |=> ##1
      port_pin_oe_n_o == $past(pwdata_i[PIN_W-1:0], 2))
      else $error("pin enables do not follow direction write");
   a_pin_drive: assert property (
      acc_w && paddr_i[7:2] == 6'h3c |=> ##1
      port_pin_o == ($past(pwdata_i[PIN_W-1:0], 2) & ~port_pin_oe_n_o))
      else $error("output pins do not carry written value");
   a_read_value: assert property (
      psel_i && !penable_i && !pwrite_i && paddr_i[7:2] == 6'h3c && quiet_r > 4'h4
      |=> prdata_o[PIN_W-1:0] == port_pin_i)
      else $error("value read differs from pin levels");
   a_status_clear: assert property (
      psel_i && penable_i && pready_o && !pwrite_i && paddr_i[7:2] == 6'h3d
      && quiet_r > 4'h6 && wr_age_r > 4'h4 |=> ##1 !port_irq_o)
      else $error("port interrupt survives status read");
   a_irq_cause: assert property (
      $rose(port_irq_o) |-> quiet_r < 4'h6 || wr_age_r < 4'h5)
      else $error("port interrupt without pin change or unmask");
   a_reset_idle: assert property (
      $fell(sys_rst_i) |-> port_pin_oe_n_o == {PIN_W{1'b1}} && !port_irq_o && !irq_o)
      else $error("pins or interrupts not idle after reset");
endmodule : universal_port_checker
bind universal_port universal_port_checker #(.PIN_W(PIN_W)) universal_port_checker_inst (.*);

//--- port_pins_model.sv
// Outside world on the eight port pins: a source the bench sets per pin.
// Assumes the port's enables are low where it drives.
`timescale 1ns/1ps
module port_pins_model #(
   parameter int PIN_W = 8
) (
   input wire logic [PIN_W-1:0] ext_lvl_i, // Level from the outside source
   input wire logic [PIN_W-1:0] drive_i, // Port drive levels
   input wire logic [PIN_W-1:0] oe_n_i, // Low where the port drives
   output logic [PIN_W-1:0] pad_o // Resolved pin level
);
   // A driven pin shows the port's level, a released one the outside source
   assign pad_o = (drive_i & ~oe_n_i) | (ext_lvl_i & oe_n_i);
endmodule : port_pins_model

//--- test_universal_port.sv
// Self-checking bench for the universal port: APB master and pin stimulus.
// Assumes the checker is bound in and the pin model resolves pad levels.
`timescale 1ns/1ps
`include "uport_cfg.svh"
module test_universal_port;
   logic ref_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
   logic port_irq_o, irq_o, clk_en_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [7:0] ext, pad, pin_o, oe_n;
   int n_mismatch = 0;
   int n_compared = 0;
   universal_port universal_port_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .clk_en_i(clk_en_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .port_pin_i(pad), .port_pin_o(pin_o), .port_pin_oe_n_o(oe_n),
      .port_irq_o(port_irq_o), .irq_o(irq_o));
   port_pins_model port_pins_model_inst (.ext_lvl_i(ext), .drive_i(pin_o), .oe_n_i(oe_n),
      .pad_o(pad));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   task final_report;
      if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [6:0] idx, input logic [7:0] wd);
      int n;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= {3'h0, idx, 2'h0};
      pwdata_i <= {24'h0, wd};
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) begin
         n_mismatch++;
         final_report();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task pin(input logic [7:0] v);
      @(posedge ref_clk_i);
      ext <= v;
   endtask : pin
   task settle;
      repeat (8) @(posedge ref_clk_i);
   endtask : settle
   task t_reset;
      chk(oe_n, 8'hff);
      apb(1'b0, `UP_IDX_DIR_A, 8'h00); chk(rd, 32'hff);
      apb(1'b0, 7'h3f, 8'h00); chk(err, 1); // unmapped index refused
   endtask : t_reset
   task t_port_io;
      pin(8'ha5);
      apb(1'b1, `UP_IDX_DIR_B, 8'h0f);
      apb(1'b1, `UP_IDX_VALUE_A, 8'h3c);
      settle();
      chk(oe_n, 8'h0f);
      chk(pin_o, 8'h30);
      apb(1'b0, `UP_IDX_VALUE_B, 8'h00); chk(rd, 32'h35);
      apb(1'b0, `UP_IDX_DIR_A, 8'h00); chk(rd, 32'h0f);
      apb(1'b1, `UP_IDX_PORT_CFG_A, 8'h80);
      apb(1'b0, `UP_IDX_STAT_B, 8'h00); chk(rd, 32'ha5);
      apb(1'b0, `UP_IDX_STAT_A, 8'h00); chk(rd, 32'h00);
      apb(1'b1, `UP_IDX_PORT_CFG_B, 8'h00);
   endtask : t_port_io
   task t_change;
      apb(1'b1, `UP_IDX_IEN, 8'h01);
      apb(1'b1, `UP_IDX_STAT_A, 8'hfe);
      pin(8'ha4); pin(8'ha5); pin(8'ha4); settle();
      chk(port_irq_o, 1);
      chk(irq_o, 1);
      apb(1'b0, `UP_IDX_SUMMARY_B, 8'h00); chk(rd, 32'h1);
      apb(1'b0, `UP_IDX_STAT_B, 8'h00); chk(rd, 32'h1);
      settle();
      chk(port_irq_o, 0);
      apb(1'b0, `UP_IDX_SUMMARY_A, 8'h00); chk(rd, 32'h0);
      apb(1'b0, `UP_IDX_STAT_A, 8'h00); chk(rd, 32'h0);
      apb(1'b1, `UP_IDX_ICLR, 8'h03); settle();
      chk(irq_o, 0);
   endtask : t_change
   task t_masked;
      pin(8'ha6); settle();
      chk(port_irq_o, 0);
      apb(1'b0, `UP_IDX_SUMMARY_A, 8'h00); chk(rd, 32'h0);
      apb(1'b0, `UP_IDX_STAT_B, 8'h00); chk(rd, 32'h0);
      apb(1'b0, `UP_IDX_IST, 8'h00); chk(rd, 32'h2);
      chk(irq_o, 0);
      apb(1'b1, `UP_IDX_STAT_A, 8'hfc); settle();
      chk(port_irq_o, 1);
      apb(1'b0, `UP_IDX_STAT_A, 8'h00); chk(rd, 32'h2);
      // Frozen port must not see the pin move until enabled again
      @(posedge ref_clk_i);
      clk_en_i <= 1'b0;
      pin(8'ha4); settle();
      chk(port_irq_o, 0);
      @(posedge ref_clk_i);
      clk_en_i <= 1'b1;
      settle();
      chk(port_irq_o, 1);
   endtask : t_masked
   initial begin
      sys_rst_i = 1'b1;
      clk_en_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      ext = 8'h00;
      repeat (10) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_port_io();
      t_change();
      t_masked();
      final_report();
   end
endmodule : test_universal_port
